// File: rtl/cir_pkg.sv
package cir_pkg;

  // Type fixed for the nonmaskable request
  localparam logic [7:0] CIR_NMI_VEC = 8'h02;
  // Synchroniser depth for asynchronous request pins
  localparam int unsigned CIR_SYNC_STAGES = 2;

  // Sources that come from the execution unit at an instruction end
  typedef struct packed {
    logic       exc;      // Processor exception pending
    logic [7:0] exc_vec;  // Its type
    logic       step;     // Single step trap pending
    logic       cso;      // Coprocessor segment overrun pulse
    logic       swi;      // Software interrupt instruction
    logic [7:0] swi_vec;  // Its type
  } cir_req_t;

  // Entry request handed to the execution unit
  typedef struct packed {
    logic [7:0] vec;       // Handler type
    logic       saved_ie;  // Flag value to push with the flags
  } cir_entry_t;

  typedef enum logic [3:0] {
    CIR_ST_IDLE  = 4'h1,
    CIR_ST_ENTRY = 4'h2,
    CIR_ST_VF1   = 4'h4,
    CIR_ST_VF2   = 4'h8
  } cir_state_t;

endpackage

// File: rtl/cir_sync.sv
`timescale 1ns/100ps
module cir_sync #(
  parameter int unsigned STAGES = 2
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic din,
  output logic      dout
);
  logic [STAGES-1:0] chain_q;
  logic [STAGES-1:0] chain_d;

  always_comb begin
    chain_d = {chain_q[STAGES-2:0], din};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      chain_q <= '0;
    end else begin
      chain_q <= chain_d;
    end
  end

  assign dout = chain_q[STAGES-1];
endmodule // cir_sync

// File: rtl/cir_recog.sv
`timescale 1ns/100ps
// What this block does
// - Fixed order: exception, step, NMI, overrun, maskable, software.
// - New interrupts are taken inside a running handler, LIFO nesting.
// - Pending requests get entry before the handler's first instruction.
// - Real mode: any entry clears the enable flag until return or set.
// - Protected mode: gate attribute decides whether entry clears flag.
// - Entry hands the handler type and the pre-entry flag value to the execution unit.
// - NMI latched on rising edge; nothing can disable it.
// - NMI vectors to type 2 internally, with no vector fetch.
// - Pending NMI recognised at an instruction boundary or at the end of an entry.
// - After a stack segment load, recognition skips that boundary and the next.
// - Active NMI handler blocks NMI and overrun until return or reset.
// - Second NMI during handler is kept and served after return.
// - Software may set the flag; return restores the pre-entry value.
// - Maskable request input is a sampled, possibly asynchronous level.
// - Flag set and request high: acknowledge at next boundary.
// - Two back-to-back vector fetches; second returns a type byte.
// - After the second fetch, control goes to the read type.
// - Bus hold is not granted during the vector fetch pair.
// - Bus lock is asserted during the first vector fetch.
module cir_recog #(
  parameter logic [7:0] STEP_VEC = 8'h01,
  parameter logic [7:0] CSO_VEC  = 8'h09
) (
  input  wire logic           clk,
  input  wire logic           srst,
  input  wire logic           nmi_pin,
  input  wire logic           maskable_request,
  input  wire logic           instr_end,
  input  wire logic           ss_load,
  input  wire cir_pkg::cir_req_t req,
  input  wire logic           return_from_interrupt,
  input  wire logic           return_from_interrupt_ie,
  input  wire logic           ie_set,
  input  wire logic           ie_clr,
  input  wire logic           prot_mode,
  input  wire logic           gate_keeps_ie,
  input  wire logic           entry_done,
  input  wire logic           vfc_ack,
  input  wire logic [7:0]     vfc_data,
  input  wire logic           bus_hold_request,
  output logic                exec_hold_q,
  output logic                entry_go_q,
  output cir_pkg::cir_entry_t entry_q,
  output logic                vfc_req_q,
  output logic                vfc_first_q,
  output logic                bus_lock_q,
  output logic                hold_gnt_q,
  output logic                ie_q,
  output logic                nmi_active_q
);
  import cir_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Request pin synchronisers

  logic nmi_s;
  logic mreq_s;

  cir_sync #(.STAGES(CIR_SYNC_STAGES)) u_sync_nmi (
    .clk  (clk),
    .srst (srst),
    .din  (nmi_pin),
    .dout (nmi_s)
  );

  cir_sync #(.STAGES(CIR_SYNC_STAGES)) u_sync_mreq (
    .clk  (clk),
    .srst (srst),
    .din  (maskable_request),
    .dout (mreq_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // Pending sources and selection

  cir_state_t state_q;
  cir_state_t state_d;
  logic       nmi_prev_q;
  logic       nmi_pend_q;
  logic       nmi_pend_d;
  logic       cso_pend_q;
  logic       cso_pend_d;
  logic       shadow_q;
  logic       shadow_d;
  logic       nmi_edge;
  logic       eval;
  logic       take_exc;
  logic       take_step;
  logic       take_nmi;
  logic       take_cso;
  logic       take_mask;
  logic       take_swi;
  logic       go_entry;
  logic [7:0] vec_sel;

  always_comb begin
    nmi_edge  = nmi_s & ~nmi_prev_q;
    // Boundary, or end of an entry with others still pending
    eval = ((state_q == CIR_ST_IDLE) && instr_end && !ss_load
            && !shadow_q)
        || ((state_q == CIR_ST_ENTRY) && entry_done);
    take_exc  = 1'b0;
    take_step = 1'b0;
    take_nmi  = 1'b0;
    take_cso  = 1'b0;
    take_mask = 1'b0;
    take_swi  = 1'b0;
    if (eval) begin
      if (req.exc) begin
        take_exc = 1'b1;
      end else if (req.step) begin
        take_step = 1'b1;
      end else if (nmi_pend_q && !nmi_active_q) begin
        take_nmi = 1'b1;
      end else if (cso_pend_q && !nmi_active_q) begin
        take_cso = 1'b1;
      end else if (mreq_s && ie_q) begin
        take_mask = 1'b1;
      end else if (req.swi) begin
        take_swi = 1'b1;
      end
    end
    go_entry = take_exc | take_step | take_nmi | take_cso | take_swi
             | ((state_q == CIR_ST_VF2) && vfc_ack);
    vec_sel = vfc_data;
    if (take_exc) begin
      vec_sel = req.exc_vec;
    end else if (take_step) begin
      vec_sel = STEP_VEC;
    end else if (take_nmi) begin
      vec_sel = CIR_NMI_VEC;
    end else if (take_cso) begin
      vec_sel = CSO_VEC;
    end else if (take_swi) begin
      vec_sel = req.swi_vec;
    end
    // New edge in the taking cycle stays pending
    nmi_pend_d = nmi_edge | (nmi_pend_q & ~take_nmi);
    cso_pend_d = req.cso | (cso_pend_q & ~take_cso);
    shadow_d   = instr_end ? ss_load : shadow_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer and outputs

  logic       nmi_active_d;
  logic       ie_d;
  cir_entry_t entry_d;
  logic       ent_nmi_q;

  always_comb begin
    state_d = state_q;
    if (go_entry) begin
      state_d = CIR_ST_ENTRY;
    end else if (take_mask) begin
      state_d = CIR_ST_VF1;
    end else if ((state_q == CIR_ST_VF1) && vfc_ack) begin
      state_d = CIR_ST_VF2;
    end else if ((state_q == CIR_ST_ENTRY) && entry_done) begin
      state_d = CIR_ST_IDLE;
    end
    ie_d = ie_q;
    if (go_entry) begin
      ie_d = prot_mode ? (ie_q & gate_keeps_ie) : 1'b0;
    end else if (return_from_interrupt) begin
      ie_d = return_from_interrupt_ie;
    end else if (ie_set) begin
      ie_d = 1'b1;
    end else if (ie_clr) begin
      ie_d = 1'b0;
    end
    nmi_active_d = nmi_active_q;
    if (take_nmi) begin
      nmi_active_d = 1'b1;
    end else if (return_from_interrupt) begin
      nmi_active_d = 1'b0;
    end
    entry_d = entry_q;
    if (go_entry) begin
      entry_d = '{vec: vec_sel, saved_ie: ie_q};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q      <= CIR_ST_IDLE;
      nmi_prev_q   <= 1'b0;
      nmi_pend_q   <= 1'b0;
      cso_pend_q   <= 1'b0;
      shadow_q     <= 1'b0;
      nmi_active_q <= 1'b0;
      ie_q         <= 1'b0;
      entry_q      <= '0;
      ent_nmi_q    <= 1'b0;
      entry_go_q   <= 1'b0;
      exec_hold_q  <= 1'b0;
      vfc_req_q    <= 1'b0;
      vfc_first_q  <= 1'b0;
      bus_lock_q   <= 1'b0;
      hold_gnt_q   <= 1'b0;
    end else begin
      state_q      <= state_d;
      nmi_prev_q   <= nmi_s;
      nmi_pend_q   <= nmi_pend_d;
      cso_pend_q   <= cso_pend_d;
      shadow_q     <= shadow_d;
      nmi_active_q <= nmi_active_d;
      ie_q         <= ie_d;
      entry_q      <= entry_d;
      ent_nmi_q    <= take_nmi;
      entry_go_q   <= go_entry;
      exec_hold_q  <= (state_d != CIR_ST_IDLE);
      vfc_req_q    <= (state_d == CIR_ST_VF1) || (state_d == CIR_ST_VF2);
      vfc_first_q  <= (state_d == CIR_ST_VF1);
      bus_lock_q   <= (state_d == CIR_ST_VF1);
      hold_gnt_q   <= bus_hold_request && (state_d != CIR_ST_VF1)
                      && (state_d != CIR_ST_VF2);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_exc_first: assert property (
    eval && req.exc |=> entry_go_q && entry_q.vec == $past(req.exc_vec))
    else $error("exception did not win priority");

  a_nmi_vector: assert property (
    entry_go_q && ent_nmi_q |-> entry_q.vec == CIR_NMI_VEC && !vfc_req_q)
    else $error("nmi entry wrong type or fetched");

  a_nmi_blocked: assert property (
    nmi_active_q |-> !take_nmi && !take_cso)
    else $error("nmi or overrun taken inside nmi handler");

  a_nmi_kept: assert property (
    nmi_active_q && nmi_pend_q && !return_from_interrupt |=> nmi_pend_q)
    else $error("second nmi lost");

  a_nmi_edge: assert property (
    $rose(nmi_s) |=> nmi_pend_q)
    else $error("nmi edge not latched");

  a_real_mask: assert property (
    go_entry && !prot_mode |=> entry_go_q && !ie_q)
    else $error("real mode entry left flag set");

  a_shadow_hold: assert property (
    instr_end && ss_load && state_q == CIR_ST_IDLE |=> !eval)
    else $error("recognition right after stack load");

  a_mask_flag: assert property (
    take_mask |-> ie_q ##1 vfc_req_q && vfc_first_q)
    else $error("maskable taken wrongly");

  a_lock_first: assert property (
    vfc_req_q && vfc_first_q |-> bus_lock_q)
    else $error("first fetch not locked");

  a_hold_vfc: assert property (
    vfc_req_q |-> !hold_gnt_q)
    else $error("hold granted during vector fetch");

  a_vf_type: assert property (
    state_q == CIR_ST_VF2 && vfc_ack |=> entry_go_q
      && entry_q.vec == $past(vfc_data) && !vfc_req_q)
    else $error("fetched type not used");

  a_chain_hold: assert property (
    state_q == CIR_ST_ENTRY && entry_done && eval && (req.exc || req.step)
      |=> exec_hold_q)
    else $error("handler ran with entry pending");

endmodule // cir_recog

// File: sim/cir_pic_model.sv
`timescale 1ns/100ps
module cir_pic_model #(
  parameter logic [7:0] TYPE_BYTE = 8'hA5
) (
  input  wire logic       clk,
  input  wire logic       raise,
  input  wire logic [3:0] wait_cyc,
  input  wire logic       vfc_req_q,
  input  wire logic       vfc_first_q,
  output logic            maskable_request,
  output logic            vfc_ack,
  output logic [7:0]      vfc_data
);
  logic [3:0] cnt;
  initial begin
    cnt = 4'h0;
    maskable_request = 1'b0;
    vfc_ack = 1'b0;
    vfc_data = 8'h00;
  end
  always @(posedge clk) begin
    vfc_ack <= 1'b0;
    vfc_data <= ~vfc_data; // Undriven bus: changing pattern
    if (raise) maskable_request <= 1'b1;
    if (vfc_req_q && !vfc_ack) begin
      if (cnt == wait_cyc) begin
        cnt <= 4'h0;
        vfc_ack <= 1'b1;
        if (vfc_first_q) maskable_request <= 1'b0;
        else vfc_data <= TYPE_BYTE;
      end else cnt <= cnt + 4'h1;
    end
  end
endmodule // cir_pic_model

// File: sim/cir_recog_tb.sv
`timescale 1ns/100ps
module cir_recog_tb;
  import cir_pkg::*;
  logic clk, srst, nmi_pin, mreq, instr_end, ss_load, return_from_interrupt, return_from_interrupt_ie;
  logic ie_set, ie_clr, prot_mode, gate_keeps_ie, entry_done, bhr;
  logic vfc_ack, raise, exec_hold_q, entry_go_q, vfc_req_q, vfc_first_q;
  logic bus_lock_q, hold_gnt_q, ie_q, nmi_active_q;
  logic [7:0] vfc_data;
  logic [3:0] wait_cyc;
  cir_req_t   req;
  cir_entry_t entry_q;
  int n_errors = 0;
  int compares = 0;
  cir_recog i_cir_recog (.clk(clk), .srst(srst), .nmi_pin(nmi_pin),
    .maskable_request(mreq), .instr_end(instr_end), .ss_load(ss_load),
    .req(req), .return_from_interrupt(return_from_interrupt), .return_from_interrupt_ie(return_from_interrupt_ie), .ie_set(ie_set),
    .ie_clr(ie_clr), .prot_mode(prot_mode), .gate_keeps_ie(gate_keeps_ie),
    .entry_done(entry_done), .vfc_ack(vfc_ack), .vfc_data(vfc_data),
    .bus_hold_request(bhr), .exec_hold_q(exec_hold_q),
    .entry_go_q(entry_go_q), .entry_q(entry_q), .vfc_req_q(vfc_req_q),
    .vfc_first_q(vfc_first_q), .bus_lock_q(bus_lock_q),
    .hold_gnt_q(hold_gnt_q), .ie_q(ie_q), .nmi_active_q(nmi_active_q));
  cir_pic_model i_cir_pic_model (.clk(clk), .raise(raise),
    .wait_cyc(wait_cyc), .vfc_req_q(vfc_req_q), .vfc_first_q(vfc_first_q),
    .maskable_request(mreq), .vfc_ack(vfc_ack), .vfc_data(vfc_data));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic bnd(input logic ss);
    instr_end = 1'b1;
    ss_load = ss;
    cyc(1);
    instr_end = 1'b0;
    ss_load = 1'b0;
  endtask
  task automatic done();
    entry_done = 1'b1;
    cyc(1);
    entry_done = 1'b0;
  endtask
  task automatic ret(input logic v);
    return_from_interrupt = 1'b1;
    return_from_interrupt_ie = v;
    cyc(1);
    return_from_interrupt = 1'b0;
  endtask
  task automatic set_ie();
    ie_set = 1'b1;
    cyc(1);
    ie_set = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_prio();
    set_ie();
    prot_mode = 1'b1;
    gate_keeps_ie = 1'b1;
    req = '{exc: 1'b1, exc_vec: 8'h30, step: 1'b1, cso: 1'b0,
            swi: 1'b1, swi_vec: 8'h80};
    bnd(1'b0);
    chk({entry_go_q, entry_q.vec}, 9'h130);
    chk(entry_q.saved_ie, 1'b1);
    chk(ie_q, 1'b1);
    req.exc = 1'b0;
    prot_mode = 1'b0;
    done();
    chk({entry_go_q, entry_q.vec}, 9'h101);
    chk(ie_q, 1'b0);
    req.step = 1'b0;
    done();
    chk({entry_go_q, entry_q.vec}, 9'h180);
    req.swi = 1'b0;
    done();
    cyc(1);
    chk(exec_hold_q, 1'b0);
    ret(1'b1);
    chk(ie_q, 1'b1);
    $display("done prio");
  endtask
  task automatic t_nmi();
    nmi_pin = 1'b1; // Held high well past four clocks
    cyc(5);
    chk(entry_go_q, 1'b0);
    bnd(1'b0);
    chk({entry_go_q, entry_q.vec}, {1'b1, CIR_NMI_VEC});
    chk(vfc_req_q, 1'b0);
    done();
    cyc(1);
    chk(nmi_active_q, 1'b1);
    nmi_pin = 1'b0;
    cyc(5);
    nmi_pin = 1'b1;
    cyc(5);
    bnd(1'b0);
    chk(entry_go_q, 1'b0);
    ret(1'b0);
    cyc(1);
    bnd(1'b0);
    chk({entry_go_q, entry_q.vec}, {1'b1, CIR_NMI_VEC});
    done();
    ret(1'b0);
    nmi_pin = 1'b0;
    cyc(2);
    $display("done nmi");
  endtask
  task automatic t_shadow();
    req.exc = 1'b1;
    req.exc_vec = 8'h0D;
    bnd(1'b1);
    chk(entry_go_q, 1'b0);
    bnd(1'b0);
    chk(entry_go_q, 1'b0);
    bnd(1'b0);
    chk({entry_go_q, entry_q.vec}, 9'h10D);
    req.exc = 1'b0;
    done();
    ret(1'b0);
    $display("done shadow");
  endtask
  task automatic t_cso();
    set_ie();
    ie_clr = 1'b1;
    cyc(1);
    ie_clr = 1'b0;
    chk(ie_q, 1'b0);
    nmi_pin = 1'b1;
    req.cso = 1'b1;
    cyc(1);
    req.cso = 1'b0;
    cyc(4);
    bnd(1'b0);
    chk({entry_go_q, entry_q.vec}, {1'b1, CIR_NMI_VEC});
    done();
    chk(entry_go_q, 1'b0);
    bnd(1'b0);
    chk(entry_go_q, 1'b0);
    ret(1'b0);
    bnd(1'b0);
    chk({entry_go_q, entry_q.vec}, 9'h109);
    done();
    nmi_pin = 1'b0;
    cyc(2);
    $display("done cso");
  endtask
  task automatic t_mask(input logic [3:0] w);
    wait_cyc = w;
    bhr = 1'b1;
    raise = 1'b1;
    cyc(1);
    raise = 1'b0;
    cyc(4); // Setup beyond two clocks
    chk(hold_gnt_q, 1'b1);
    bnd(1'b0);
    chk(vfc_req_q, 1'b0);
    set_ie();
    bnd(1'b0);
    chk({vfc_req_q, vfc_first_q, bus_lock_q}, 3'h7);
    for (int i = 0; i < 40 && !entry_go_q; i++) begin
      chk(hold_gnt_q, 1'b0);
      chk(bus_lock_q, vfc_first_q);
      cyc(1);
    end
    chk({entry_go_q, entry_q.vec}, 9'h1A5);
    chk(vfc_req_q, 1'b0);
    chk(ie_q, 1'b0);
    done();
    bhr = 1'b0;
    ret(1'b0);
    $display("done mask");
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    end_sim();
  end
  initial begin
    {srst, nmi_pin, instr_end, ss_load, return_from_interrupt, return_from_interrupt_ie, ie_set} = 7'h40;
    {ie_clr, prot_mode, gate_keeps_ie, entry_done, bhr, raise} = 6'h00;
    wait_cyc = 4'h0;
    req = '0;
    cyc(16);
    srst = 1'b0;
    cyc(2);
    t_prio();
    t_nmi();
    t_shadow();
    t_cso();
    t_mask(4'h0);
    t_mask(4'h3);
    end_sim();
  end
endmodule // cir_recog_tb
